// file: dma_channel_register_set_map.svh
`ifndef DMA_CHANNEL_REGISTER_SET_MAP_SVH
`define DMA_CHANNEL_REGISTER_SET_MAP_SVH

// Per-channel block: byte offset = channel * stride + register offset
`define CH_STRIDE          12'h020
`define CH_IDX_LSB         5
`define CH_IDX_MSB         7
`define REG_OFF_MSB        4
`define OFF_CONTROL        5'h00
`define OFF_REQ_SELECT     5'h04
`define OFF_PRIMARY        5'h08
`define OFF_SECONDARY      5'h0c
`define OFF_PERIPH_ADDR    5'h10
`define OFF_COUNT          5'h14

// Shared registers
`define SHARED_BASE        12'h100
`define OFF_STATUS0        12'h100
`define OFF_STATUS1        12'h104
`define OFF_INT_MASK       12'h108

// Control field positions
`define CTL_ENABLE_BIT     15
`define CTL_DIR_BIT        13
`define CTL_PINGPONG_BIT   1
`define CTL_ONESHOT_BIT    0

// Shared status 1 field positions
`define ST1_BUF_LSB        8
`define ST1_BUSY_BIT       7

// Reset values
`define RESET_WORD         16'h0000
`define RESET_COUNT        10'h000

`endif

// file: dma_types_pkg.sv
package dma_types_pkg;
  typedef logic [15:0] word_type;
  typedef logic [9:0]  count_type;
  typedef enum logic [1:0] {st_idle, st_fetch, st_store} engine_state_type;
endpackage

// file: xfer_if.sv
`timescale 1ns/1ns
`default_nettype none
interface xfer_if;
  import dma_types_pkg::*;
  logic     start;
  logic     dir;
  word_type periph_addr;
  word_type ram_addr;
  logic     busy;
  logic     done;
  modport issuer (output start, dir, periph_addr, ram_addr, input busy, done);
  modport engine (input start, dir, periph_addr, ram_addr, output busy, done);
endinterface
`default_nettype wire

// file: dma_transfer_engine.sv
`timescale 1ns/1ns
`default_nettype none
module dma_transfer_engine
  import dma_types_pkg::*;
(
  input  wire logic     pclk,
  input  wire logic     presetn,
  xfer_if.engine        xfer,
  output word_type      periph_addr,
  output word_type      periph_wdata,
  input  wire word_type periph_rdata,
  output logic          periph_rd,
  output logic          periph_wr,
  input  wire logic     periph_ready,
  output word_type      ram_addr,
  output word_type      ram_wdata,
  input  wire word_type ram_rdata,
  output logic          ram_rd,
  output logic          ram_wr,
  input  wire logic     ram_ready
);
  engine_state_type state, next_state;
  logic     dir, next_dir;
  word_type next_periph_addr, next_periph_wdata, next_ram_addr, next_ram_wdata;
  logic     next_periph_rd, next_periph_wr, next_ram_rd, next_ram_wr;
  logic     src_ready, dst_ready;

  assign src_ready = dir ? ram_ready : periph_ready;
  assign dst_ready = dir ? periph_ready : ram_ready;
  assign xfer.busy = (state != st_idle);
  assign xfer.done = (state == st_store) && dst_ready;

  always_comb begin
    next_state        = state;
    next_dir          = dir;
    next_periph_addr  = periph_addr;
    next_periph_wdata = periph_wdata;
    next_ram_addr     = ram_addr;
    next_ram_wdata    = ram_wdata;
    next_periph_rd    = periph_rd;
    next_periph_wr    = periph_wr;
    next_ram_rd       = ram_rd;
    next_ram_wr       = ram_wr;
    unique case (state)
      st_idle: begin
        if (xfer.start) begin
          next_dir         = xfer.dir;
          next_periph_addr = xfer.periph_addr;
          next_ram_addr    = xfer.ram_addr;
          next_periph_rd   = !xfer.dir;
          next_ram_rd      = xfer.dir;
          next_state       = st_fetch;
        end
      end
      st_fetch: begin
        if (src_ready) begin
          next_periph_rd = 1'b0;
          next_ram_rd    = 1'b0;
          if (dir) begin
            next_periph_wdata = ram_rdata;
            next_periph_wr    = 1'b1;
          end else begin
            next_ram_wdata = periph_rdata;
            next_ram_wr    = 1'b1;
          end
          next_state = st_store;
        end
      end
      st_store: begin
        if (dst_ready) begin
          next_periph_wr = 1'b0;
          next_ram_wr    = 1'b0;
          next_state     = st_idle;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state        <= st_idle;
      dir          <= 1'b0;
      periph_addr  <= '0;
      periph_wdata <= '0;
      ram_addr     <= '0;
      ram_wdata    <= '0;
      periph_rd    <= 1'b0;
      periph_wr    <= 1'b0;
      ram_rd       <= 1'b0;
      ram_wr       <= 1'b0;
    end else begin
      state        <= next_state;
      dir          <= next_dir;
      periph_addr  <= next_periph_addr;
      periph_wdata <= next_periph_wdata;
      ram_addr     <= next_ram_addr;
      ram_wdata    <= next_ram_wdata;
      periph_rd    <= next_periph_rd;
      periph_wr    <= next_periph_wr;
      ram_rd       <= next_ram_rd;
      ram_wr       <= next_ram_wr;
    end
  end
endmodule
`default_nettype wire

// file: dma_channel_register_set.sv
// How it works
// - There are eight independent channels, each with its own full register set.
// - Each channel has a 16-bit control register holding its configuration.
// - Each channel has a 16-bit request select register naming the request that starts it.
// - Each channel has a 16-bit primary start offset into the DMA RAM.
// - Each channel has a 16-bit secondary start offset into the DMA RAM.
// - Each channel has a 10-bit transfer count register.
// - Two status registers are shared by all channels.
// - Each channel has a 16-bit read/write peripheral address register reset to zero.
// - A channel performs the programmed count plus one transfers per block.
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "dma_channel_register_set_map.svh"
module dma_channel_register_set
  import dma_types_pkg::*;
#(
  parameter int NUM_CH    = 8,
  parameter int REQ_LINES = 16
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [REQ_LINES-1:0] request_lines,
  output word_type                  periph_addr,
  output word_type                  periph_wdata,
  input  wire word_type             periph_rdata,
  output logic                      periph_rd,
  output logic                      periph_wr,
  input  wire logic                 periph_ready,
  output word_type                  ram_addr,
  output word_type                  ram_wdata,
  input  wire word_type             ram_rdata,
  output logic                      ram_rd,
  output logic                      ram_wr,
  input  wire logic                 ram_ready,
  output logic                      irq
);
  localparam int SEL_W = (REQ_LINES > 1) ? $clog2(REQ_LINES) : 1;

  // Per-channel register file
  word_type  channel_control_reg        [NUM_CH];
  word_type  request_source_select_reg  [NUM_CH];
  word_type  primary_start_offset_reg   [NUM_CH];
  word_type  secondary_start_offset_reg [NUM_CH];
  word_type  peripheral_address_reg     [NUM_CH];
  count_type transfer_count_reg         [NUM_CH];
  count_type done_count                 [NUM_CH];

  word_type  next_control               [NUM_CH];
  word_type  next_req_select            [NUM_CH];
  word_type  next_primary               [NUM_CH];
  word_type  next_secondary             [NUM_CH];
  word_type  next_periph_addr           [NUM_CH];
  count_type next_count                 [NUM_CH];
  count_type next_done_count            [NUM_CH];

  // Per-channel flags
  logic [NUM_CH-1:0] buffer_sel;
  logic [NUM_CH-1:0] next_buffer_sel;
  logic [NUM_CH-1:0] pending;
  logic [NUM_CH-1:0] next_pending;
  logic [NUM_CH-1:0] req_hit;
  logic [NUM_CH-1:0] block_done;
  logic [NUM_CH-1:0] enabled;

  // Shared status and engine bookkeeping
  word_type          shared_status_reg_0;
  word_type          next_status0;
  word_type          shared_status_reg_1;
  word_type          int_mask;
  word_type          next_int_mask;
  logic [2:0]        active_ch;
  logic [2:0]        next_active_ch;
  logic [2:0]        issue_ch;
  logic              issue;

  // Bus decode
  logic [31:0]       next_prdata;
  logic              next_pslverr;
  logic              wr_access;
  logic              in_channels;
  logic [2:0]        sel_ch;
  logic [4:0]        sel_off;
  word_type          wdata16;

  xfer_if xfer ();

  // One engine serves all channels over its own ports
  dma_transfer_engine dma_transfer_engine_i (
    .pclk         (pclk),
    .presetn      (presetn),
    .xfer         (xfer.engine),
    .periph_addr  (periph_addr),
    .periph_wdata (periph_wdata),
    .periph_rdata (periph_rdata),
    .periph_rd    (periph_rd),
    .periph_wr    (periph_wr),
    .periph_ready (periph_ready),
    .ram_addr     (ram_addr),
    .ram_wdata    (ram_wdata),
    .ram_rdata    (ram_rdata),
    .ram_rd       (ram_rd),
    .ram_wr       (ram_wr),
    .ram_ready    (ram_ready)
  );

  // Zero-wait slave: writes land in the access phase
  assign pready      = 1'b1;
  assign wr_access   = psel && penable && pwrite;
  assign in_channels = paddr < `SHARED_BASE;
  assign sel_ch      = paddr[`CH_IDX_MSB:`CH_IDX_LSB];
  assign sel_off     = paddr[`REG_OFF_MSB:0];
  assign wdata16     = pwdata[15:0];

  // Level interrupt from unmasked completion flags
  assign irq         = |(shared_status_reg_0 & int_mask);

  // Request matching per channel
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : gen_ch
      logic [SEL_W-1:0] src;

      assign src        = request_source_select_reg[g][SEL_W-1:0];
      assign enabled[g] = channel_control_reg[g][`CTL_ENABLE_BIT];
      assign req_hit[g] = enabled[g] && request_lines[src];
      assign block_done[g] = xfer.done && (active_ch == 3'(g))
                             && (done_count[g] == transfer_count_reg[g]);
    end
  endgenerate

  // Lowest pending channel wins the engine
  always_comb begin
    issue    = 1'b0;
    issue_ch = 3'd0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (pending[i]) begin
        issue    = !xfer.busy;
        issue_ch = 3'(i);
      end
    end
  end

  // Winning channel's next transfer
  assign xfer.start       = issue;
  assign xfer.dir         = channel_control_reg[issue_ch][`CTL_DIR_BIT];
  assign xfer.periph_addr = peripheral_address_reg[issue_ch];
  assign xfer.ram_addr    = (buffer_sel[issue_ch] ? secondary_start_offset_reg[issue_ch]
                                                  : primary_start_offset_reg[issue_ch])
                            + word_type'(done_count[issue_ch]);

  // Shared status 1: buffer in use, engine busy, active channel
  always_comb begin
    shared_status_reg_1 = '0;
    shared_status_reg_1[`ST1_BUF_LSB +: NUM_CH] = buffer_sel;
    shared_status_reg_1[`ST1_BUSY_BIT]          = xfer.busy;
    shared_status_reg_1[2:0]                    = active_ch;
  end

  always_comb begin
    next_control     = channel_control_reg;
    next_req_select  = request_source_select_reg;
    next_primary     = primary_start_offset_reg;
    next_secondary   = secondary_start_offset_reg;
    next_periph_addr = peripheral_address_reg;
    next_count       = transfer_count_reg;
    next_done_count  = done_count;
    next_buffer_sel  = buffer_sel;
    next_int_mask    = int_mask;
    next_active_ch   = issue ? issue_ch : active_ch;
    next_pending     = pending;

    if (issue) begin
      next_pending[issue_ch] = 1'b0;
    end
    next_pending = (next_pending | req_hit) & enabled;

    // Completion of one transfer
    if (xfer.done) begin
      if (block_done[active_ch]) begin
        next_done_count[active_ch] = `RESET_COUNT;
        if (channel_control_reg[active_ch][`CTL_PINGPONG_BIT]) begin
          next_buffer_sel[active_ch] = !buffer_sel[active_ch];
        end
        if (channel_control_reg[active_ch][`CTL_ONESHOT_BIT]) begin
          next_control[active_ch][`CTL_ENABLE_BIT] = 1'b0;
        end
      end else begin
        next_done_count[active_ch] = done_count[active_ch] + 10'h001;
      end
    end

    // Completion flags: a set in the same cycle beats a write-one clear
    next_status0 = shared_status_reg_0;
    if (wr_access && paddr == `OFF_STATUS0) begin
      next_status0 = shared_status_reg_0 & ~wdata16;
    end
    next_status0[NUM_CH-1:0] = next_status0[NUM_CH-1:0] | block_done;

    // Software writes to the channel block
    if (wr_access && in_channels) begin
      unique case (sel_off)
        `OFF_CONTROL: begin
          next_control[sel_ch] = wdata16;
          if (!enabled[sel_ch] && wdata16[`CTL_ENABLE_BIT]) begin
            next_done_count[sel_ch] = `RESET_COUNT;
            next_buffer_sel[sel_ch] = 1'b0;
          end
        end
        `OFF_REQ_SELECT:  next_req_select[sel_ch]  = wdata16;
        `OFF_PRIMARY:     next_primary[sel_ch]     = wdata16;
        `OFF_SECONDARY:   next_secondary[sel_ch]   = wdata16;
        `OFF_PERIPH_ADDR: next_periph_addr[sel_ch] = wdata16;
        `OFF_COUNT:       next_count[sel_ch]       = wdata16[9:0];
        default: ;
      endcase
    end

    if (wr_access && paddr == `OFF_INT_MASK) begin
      next_int_mask = wdata16;
    end
  end

  // Read data is captured in the setup phase and stands in the access phase
  always_comb begin
    next_prdata  = '0;
    next_pslverr = 1'b0;

    if (psel && !penable) begin
      if (in_channels) begin
        unique case (sel_off)
          `OFF_CONTROL:     next_prdata[15:0] = channel_control_reg[sel_ch];
          `OFF_REQ_SELECT:  next_prdata[15:0] = request_source_select_reg[sel_ch];
          `OFF_PRIMARY:     next_prdata[15:0] = primary_start_offset_reg[sel_ch];
          `OFF_SECONDARY:   next_prdata[15:0] = secondary_start_offset_reg[sel_ch];
          `OFF_PERIPH_ADDR: next_prdata[15:0] = peripheral_address_reg[sel_ch];
          `OFF_COUNT:       next_prdata[9:0]  = transfer_count_reg[sel_ch];
          default:          next_pslverr      = 1'b1;
        endcase
      end else if (paddr == `OFF_STATUS0) begin
        next_prdata[15:0] = shared_status_reg_0;
      end else if (paddr == `OFF_STATUS1) begin
        next_prdata[15:0] = shared_status_reg_1;
      end else if (paddr == `OFF_INT_MASK) begin
        next_prdata[15:0] = int_mask;
      end else begin
        next_pslverr = 1'b1;
      end
    end else if (psel) begin
      next_prdata  = prdata;
      next_pslverr = pslverr;
    end
  end

  // Every register of the block loads here except shared status 1, which is built from other state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        channel_control_reg[i]        <= `RESET_WORD;
        request_source_select_reg[i]  <= `RESET_WORD;
        primary_start_offset_reg[i]   <= `RESET_WORD;
        secondary_start_offset_reg[i] <= `RESET_WORD;
        peripheral_address_reg[i]     <= `RESET_WORD;
        transfer_count_reg[i]         <= `RESET_COUNT;
        done_count[i]                 <= `RESET_COUNT;
      end

      buffer_sel          <= '0;
      pending             <= '0;
      shared_status_reg_0 <= `RESET_WORD;
      int_mask            <= `RESET_WORD;
      active_ch           <= 3'd0;
      prdata              <= '0;
      pslverr             <= 1'b0;
    end else begin
      channel_control_reg        <= next_control;
      request_source_select_reg  <= next_req_select;
      primary_start_offset_reg   <= next_primary;
      secondary_start_offset_reg <= next_secondary;
      peripheral_address_reg     <= next_periph_addr;
      transfer_count_reg         <= next_count;
      done_count                 <= next_done_count;

      buffer_sel                 <= next_buffer_sel;
      pending                    <= next_pending;

      shared_status_reg_0        <= next_status0;
      int_mask                   <= next_int_mask;
      active_ch                  <= next_active_ch;
      prdata                     <= next_prdata;
      pslverr                    <= next_pslverr;
    end
  end
endmodule
`default_nettype wire

// file: dma_channel_register_set_sva.sv
`timescale 1ns/1ns
`default_nettype none
module dma_channel_register_set_sva
  import dma_types_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire word_type    periph_addr,
  input wire word_type    periph_wdata,
  input wire word_type    periph_rdata,
  input wire logic        periph_rd,
  input wire logic        periph_wr,
  input wire logic        periph_ready,
  input wire word_type    ram_addr,
  input wire word_type    ram_wdata,
  input wire word_type    ram_rdata,
  input wire logic        ram_rd,
  input wire logic        ram_wr,
  input wire logic        ram_ready
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_src_periph; periph_rd && periph_ready; endsequence
  sequence s_src_ram; ram_rd && ram_ready; endsequence
  property p_unmapped; s_setup ##0 (paddr >= 12'h10c) |=> pslverr; endproperty
  property p_mapped;
    s_setup ##0 (paddr < 12'h100 && paddr[4:0] <= 5'h14 && paddr[1:0] == 2'b00) |=> !pslverr;
  endproperty
  property p_upper; psel && penable |-> pready && prdata[31:16] == 16'h0000; endproperty
  property p_count;
    s_setup ##0 (!pwrite && paddr < 12'h100 && paddr[4:0] == 5'h14) |=> prdata[15:10] == 6'h00;
  endproperty
  property p_one_strobe; $onehot0({periph_rd, periph_wr, ram_rd, ram_wr}); endproperty
  property p_rd_hold; periph_rd && !periph_ready |=> periph_rd && $stable(periph_addr); endproperty
  property p_wr_hold;
    ram_wr && !ram_ready |=> ram_wr && $stable(ram_addr) && $stable(ram_wdata);
  endproperty
  property p_to_ram;
    s_src_periph |=> !periph_rd && ram_wr && ram_wdata == $past(periph_rdata);
  endproperty
  property p_to_periph;
    s_src_ram |=> !ram_rd && periph_wr && periph_wdata == $past(ram_rdata);
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access without slave error");
  a_mapped: assert property (p_mapped)
    else $error("mapped access flagged as error");
  a_upper: assert property (p_upper)
    else $error("read data upper half not zero");
  a_count: assert property (p_count)
    else $error("count read wider than ten bits");
  a_one_strobe: assert property (p_one_strobe)
    else $error("more than one transfer strobe");
  a_rd_hold: assert property (p_rd_hold)
    else $error("peripheral read dropped before ready");
  a_wr_hold: assert property (p_wr_hold)
    else $error("ram write dropped before ready");
  a_to_ram: assert property (p_to_ram)
    else $error("peripheral data not written to ram");
  a_to_periph: assert property (p_to_periph)
    else $error("ram data not written to peripheral");
endmodule
bind dma_channel_register_set dma_channel_register_set_sva dma_channel_register_set_sva_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .periph_addr(periph_addr), .periph_wdata(periph_wdata), .periph_rdata(periph_rdata),
  .periph_rd(periph_rd), .periph_wr(periph_wr), .periph_ready(periph_ready),
  .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata),
  .ram_rd(ram_rd), .ram_wr(ram_wr), .ram_ready(ram_ready)
);
`default_nettype wire

// file: dma_far_side_model.sv
`timescale 1ns/1ns
`default_nettype none
module dma_far_side_model
  import dma_types_pkg::*;
(
  input  wire logic     pclk,
  input  wire logic     presetn,
  input  wire logic     slow,
  input  wire word_type periph_addr,
  input  wire word_type periph_wdata,
  input  wire logic     periph_rd,
  input  wire logic     periph_wr,
  output word_type      periph_rdata,
  output logic          periph_ready,
  input  wire word_type ram_addr,
  input  wire word_type ram_wdata,
  input  wire logic     ram_rd,
  input  wire logic     ram_wr,
  output word_type      ram_rdata,
  output logic          ram_ready,
  output logic [15:0]   writes,
  output word_type      last_addr,
  output word_type      last_data,
  output logic          last_to_ram
);
  logic [1:0] p_wait;
  logic [1:0] r_wait;
  word_type   cyc;
  // Slow mode answers after two wait cycles
  assign periph_ready = (periph_rd | periph_wr) & (~slow | (p_wait == 2'd2));
  assign ram_ready    = (ram_rd | ram_wr) & (~slow | (r_wait == 2'd2));
  // Undriven data changes every cycle
  assign periph_rdata = periph_rd ? (periph_addr ^ 16'h5a5a) : cyc;
  assign ram_rdata    = ram_rd ? (ram_addr + 16'h1000) : ~cyc;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p_wait <= 2'd0;
      r_wait <= 2'd0;
      cyc <= 16'h0000;
      writes <= 16'h0000;
      last_addr <= 16'h0000;
      last_data <= 16'h0000;
      last_to_ram <= 1'b0;
    end else begin
      cyc <= cyc + 16'h3c01;
      p_wait <= ((periph_rd | periph_wr) & ~periph_ready) ? p_wait + 2'd1 : 2'd0;
      r_wait <= ((ram_rd | ram_wr) & ~ram_ready) ? r_wait + 2'd1 : 2'd0;
      if (ram_wr & ram_ready) begin
        writes <= writes + 16'h0001;
        last_addr <= ram_addr;
        last_data <= ram_wdata;
        last_to_ram <= 1'b1;
      end else if (periph_wr & periph_ready) begin
        writes <= writes + 16'h0001;
        last_addr <= periph_addr;
        last_data <= periph_wdata;
        last_to_ram <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// file: dma_channel_register_set_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "dma_channel_register_set_map.svh"
module dma_channel_register_set_tb_top
  import dma_types_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [15:0] request_lines = 16'h0000;
  logic        slow = 1'b0;
  logic [31:0] prdata;
  logic        pready, pslverr, irq, last_to_ram;
  logic        periph_rd, periph_wr, periph_ready, ram_rd, ram_wr, ram_ready;
  word_type    periph_addr, periph_wdata, periph_rdata, ram_addr, ram_wdata, ram_rdata;
  word_type    last_addr, last_data;
  logic [15:0] writes;
  logic [31:0] q;
  logic        e;
  int          num_errors = 0;
  int          checked = 0;
  always #20 pclk = ~pclk;
  dma_channel_register_set dma_channel_register_set_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .request_lines(request_lines), .periph_addr(periph_addr), .periph_wdata(periph_wdata),
    .periph_rdata(periph_rdata), .periph_rd(periph_rd), .periph_wr(periph_wr),
    .periph_ready(periph_ready), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .ram_rdata(ram_rdata), .ram_rd(ram_rd), .ram_wr(ram_wr), .ram_ready(ram_ready), .irq(irq));
  dma_far_side_model dma_far_side_model_i (
    .pclk(pclk), .presetn(presetn), .slow(slow), .periph_addr(periph_addr),
    .periph_wdata(periph_wdata), .periph_rd(periph_rd), .periph_wr(periph_wr),
    .periph_rdata(periph_rdata), .periph_ready(periph_ready), .ram_addr(ram_addr),
    .ram_wdata(ram_wdata), .ram_rd(ram_rd), .ram_wr(ram_wr), .ram_rdata(ram_rdata),
    .ram_ready(ram_ready), .writes(writes), .last_addr(last_addr), .last_data(last_data),
    .last_to_ram(last_to_ram));
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string s);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp, input string s);
    check_word({31'h0, got}, {31'h0, exp}, s);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Callers then see outputs settled after the write
    @(negedge pclk);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic err);
    apb(1'b0, a, 32'h0);
    check_word(q, exp, "read data");
    check_bit(e, err, "slave error");
  endtask
  function automatic logic [11:0] ra(input int c, input int k);
    return 12'(c) * `CH_STRIDE + 12'(k * 4);
  endfunction
  function automatic logic [15:0] val(input int c, input int k);
    return (k == 0) ? 16'(c % 4) : (k == 1) ? 16'(c) : 16'(16'h1357 * k + 16'h0f01 * c);
  endfunction
  task automatic pulse(input int line, input logic expect_xfer);
    int n = 0;
    logic [15:0] w0;
    w0 = writes;
    @(posedge pclk);
    request_lines[line] <= 1'b1;
    @(posedge pclk);
    request_lines[line] <= 1'b0;
    while (writes === w0 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    check_bit(writes !== w0, expect_xfer, "transfer seen");
  endtask
  task automatic wrap_up;
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #800000;
    num_errors++;
    wrap_up;
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      for (int k = 0; k < 6; k++) rd_chk(ra(c, k), 32'h0, 1'b0);
    end
    $display("test reset values done");
    // Channels disabled while addresses are written
    for (int c = 0; c < 8; c++) begin
      for (int k = 0; k < 6; k++) apb(1'b1, ra(c, k), {16'hffff, val(c, k)});
    end
    for (int c = 0; c < 8; c++) begin
      for (int k = 0; k < 6; k++) begin
        rd_chk(ra(c, k), {16'h0, val(c, k) & ((k == 5) ? 16'h03ff : 16'hffff)}, 1'b0);
      end
    end
    $display("test channel registers done");
    rd_chk(12'h1f0, 32'h0, 1'b1);
    apb(1'b1, 12'h018, 32'h1234);
    rd_chk(12'h018, 32'h0, 1'b1);
    $display("test unmapped done");
    slow <= 1'b1;
    apb(1'b1, ra(2, 4), 32'h0040);
    apb(1'b1, ra(2, 2), 32'h0200);
    apb(1'b1, ra(2, 5), 32'h0003);
    apb(1'b1, ra(2, 1), 32'h0005);
    apb(1'b1, `OFF_INT_MASK, 32'h0004);
    apb(1'b1, ra(2, 0), 32'h8001);
    for (int i = 0; i < 4; i++) pulse(5, 1'b1);
    pulse(5, 1'b0);
    check_word({16'h0, writes}, 32'd4, "transfer total");
    check_word({last_addr, last_data}, {16'h0203, 16'h5a1a}, "last");
    check_bit(last_to_ram, 1'b1, "to ram");
    rd_chk(`OFF_STATUS0, 32'h0004, 1'b0);
    rd_chk(`OFF_STATUS1, 32'h0002, 1'b0);
    rd_chk(ra(2, 0), 32'h0001, 1'b0);
    check_bit(irq, 1'b1, "irq raised");
    apb(1'b1, `OFF_INT_MASK, 32'h0000);
    check_bit(irq, 1'b0, "irq masked");
    apb(1'b1, `OFF_INT_MASK, 32'h0004);
    check_bit(irq, 1'b1, "irq unmasked");
    apb(1'b1, `OFF_STATUS0, 32'h0004);
    check_bit(irq, 1'b0, "irq cleared");
    $display("test ram block done");
    slow <= 1'b0;
    apb(1'b1, ra(7, 4), 32'h0300);
    apb(1'b1, ra(7, 2), 32'h0480);
    apb(1'b1, ra(7, 5), 32'h0000);
    apb(1'b1, ra(7, 1), 32'h000f);
    apb(1'b1, ra(7, 0), 32'ha002);
    pulse(15, 1'b1);
    check_word({last_addr, last_data}, {16'h0300, 16'h1480}, "last");
    check_bit(last_to_ram, 1'b0, "to periph");
    rd_chk(`OFF_STATUS1, 32'h8007, 1'b0);
    pulse(15, 1'b1);
    check_word({last_addr, last_data}, {16'h0300, 16'hb30c}, "last");
    apb(1'b1, ra(7, 0), 32'h0000);
    pulse(15, 1'b0);
    rd_chk(`OFF_STATUS0, 32'h0080, 1'b0);
    $display("test peripheral block done");
    wrap_up;
  end
endmodule
`default_nettype wire
